/* File: cfg_port_map.svh */
// Offsets, field positions, widths and reset values of the serial configuration port
`ifndef CFG_PORT_MAP_SVH
`define CFG_PORT_MAP_SVH
`define WORD_W          32
`define ADDR_BITS       5
`define DATA_BITS       27
`define NUM_CFG         32
`define AXI_ADDR_W      8
`define CFG_BASE        8'h00
`define CTRL_OFFSET     8'h80
`define STATUS_OFFSET   8'h84
`define CTRL_ALIGN_BIT  0
`define CTRL_RBLE_BIT   1
`define STAT_ADDR_LSB   0
`define STAT_COUNT_LSB  16
`define COUNT_W         16
`define LE_SYNC_STAGES  3
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define CTRL_RESET      2'h0
`endif

/* File: cfg_port_pkg.sv */
// Types for the serial configuration port
`include "cfg_port_map.svh"
package cfg_port_pkg;
  typedef struct packed {
    logic [`WORD_W-1:0] shift_word;
  } link_state_t;

  typedef struct packed {
    logic [`LE_SYNC_STAGES-1:0]               le_sync;
    logic                                     le_level;
    logic [`NUM_CFG-1:0][`DATA_BITS-1:0]      cfg;
    logic [1:0]                               ctrl;
    logic                                     align_event;
    logic [`COUNT_W-1:0]                      commit_count;
    logic [`ADDR_BITS-1:0]                    last_addr;
    logic [`AXI_ADDR_W-1:0]                   awaddr;
    logic                                     aw_have;
    logic [31:0]                              wdata;
    logic [3:0]                               wstrb;
    logic                                     w_have;
    logic                                     awready;
    logic                                     wready;
    logic                                     bvalid;
    logic [1:0]                               bresp;
    logic                                     arready;
    logic                                     rvalid;
    logic [31:0]                              rdata;
    logic [1:0]                               rresp;
  } core_state_t;
endpackage : cfg_port_pkg

/* File: three_wire_config_write_port.sv */
// Three-wire serial configuration write port with an AXI4-Lite register view
//
// What this block does and what the host must do
// [R1] Serial data is shifted into the shift register on every serial clock rising edge.
// [R2] Latch enable rising edge copies the shifted word into the addressed register.
// [R3] Target register address is the last five bits shifted before latch rises.
// [R4] Readback does not stop shifting; a later latch rise still writes the register.
// [R5] With auto-alignment enabled, latch enable falling edge fires an alignment event.
// [R6] Host uses extra clocks or a double write for large divider or delay values.
// [R7] Host gives three extra clocks with latch high to keep auto-alignment on.
// [R8] Host should return clock, data and latch lines low after programming.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "cfg_port_map.svh"
module three_wire_config_write_port
  import cfg_port_pkg::*;
(
  // System clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Serial link pins
  input  wire logic                    serial_clock_in,
  input  wire logic                    serial_data_in,
  input  wire logic                    latch_enable_in,
  // Alignment event output
  output logic                         align_event,
  // AXI4-Lite write address
  input  wire logic [`AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  link_state_t lq;
  link_state_t next_lq;
  core_state_t q;
  core_state_t next_q;

  // Link domain: the serial clock only runs during frames, so nothing here
  // depends on an edge outside a frame. Extra clocks given by the host for
  // extended loads simply shift further; the last five bits still address.
  always_comb begin
    next_lq = lq;
    next_lq.shift_word = {lq.shift_word[`WORD_W-2:0], serial_data_in}; // [R1] [R4] [R6] [R7]
  end

  always_ff @(posedge serial_clock_in or posedge rst) begin
    if (rst) begin
      lq <= '0;
    end else begin
      lq <= next_lq;
    end
  end

  // Core domain
  logic                   le_stable;
  logic                   le_rise;
  logic                   le_fall;
  logic [`ADDR_BITS-1:0]  commit_addr;
  logic [`DATA_BITS-1:0]  commit_data;
  logic [31:0]            wmask;
  logic [31:0]            ctrl_word;
  logic [31:0]            status_word;
  logic                   aw_take;
  logic                   w_take;
  logic                   b_take;
  logic                   ar_take;
  logic                   r_take;
  logic                   wr_go;
  logic [31:0]            ctrl_merged;
  logic                   wr_hit_ctrl;
  logic                   wr_hit_ro;
  logic [1:0]             wr_resp;
  logic [`ADDR_BITS-1:0]  rd_index;
  logic                   rd_hit_cfg;
  logic                   rd_hit_ctrl;
  logic                   rd_hit_status;
  logic [31:0]            rd_word;
  logic [1:0]             rd_resp;

  // Latch enable passes three flops; an edge counts once stages two and three agree.
  assign le_stable = (q.le_sync[1] == q.le_sync[2]);
  assign le_rise   = le_stable && q.le_sync[2] && !q.le_level;
  assign le_fall   = le_stable && !q.le_sync[2] && q.le_level;

  // The shift word is read straight across: the serial clock must stay idle
  // for at least 25 ns after the latch rises, and the latch edge is seen here
  // within four core cycles (20 ns), so the word is stable when taken.
  assign commit_addr = lq.shift_word[`ADDR_BITS-1:0];                  // [R3]
  assign commit_data = lq.shift_word[`WORD_W-1:`ADDR_BITS];

  assign wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};

  // One item moves per channel at an edge where its valid and ready are both high
  assign aw_take = q.awready && s_axi_awvalid;
  assign w_take  = q.wready && s_axi_wvalid;
  assign b_take  = q.bvalid && s_axi_bready;
  assign ar_take = q.arready && s_axi_arvalid;
  assign r_take  = q.rvalid && s_axi_rready;
  // A write is acted on once both halves are held and no answer is pending
  assign wr_go   = q.aw_have && q.w_have && !q.bvalid;

  // Byte strobes pick which lanes of the control word change
  assign ctrl_merged = (ctrl_word & ~wmask) | (q.wdata & wmask);

  // Configuration and status words only change from the link, so a bus write
  // to them or to any address below 0x80 is accepted and dropped; any other address but control (0x80) is an error
  always_comb begin
    wr_hit_ctrl = (q.awaddr == `CTRL_OFFSET);
    wr_hit_ro   = (q.awaddr == `STATUS_OFFSET) || (q.awaddr < `CTRL_OFFSET);
    if (wr_hit_ctrl || wr_hit_ro) begin
      wr_resp = `RESP_OKAY;
    end else begin
      wr_resp = `RESP_SLVERR;
    end
  end

  // Read decode works on the offered address so the answer stands one edge later
  always_comb begin
    rd_index      = s_axi_araddr[`ADDR_BITS+1:2];
    rd_hit_cfg    = (s_axi_araddr < `CTRL_OFFSET) && (s_axi_araddr[1:0] == 2'b00);
    rd_hit_ctrl   = (s_axi_araddr == `CTRL_OFFSET);
    rd_hit_status = (s_axi_araddr == `STATUS_OFFSET);
    rd_word       = 32'h0;
    rd_resp       = `RESP_OKAY;
    if (rd_hit_cfg) begin
      rd_word = {5'h0, q.cfg[rd_index]};
    end else if (rd_hit_ctrl) begin
      rd_word = ctrl_word;
    end else if (rd_hit_status) begin
      rd_word = status_word;
    end else begin
      rd_resp = `RESP_SLVERR;
    end
  end

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[1:0] = q.ctrl;
    status_word = 32'h0;
    status_word[`STAT_ADDR_LSB +: `ADDR_BITS] = q.last_addr;
    status_word[`STAT_COUNT_LSB +: `COUNT_W] = q.commit_count;
  end

  always_comb begin
    next_q = q;
    next_q.le_sync = {q.le_sync[`LE_SYNC_STAGES-2:0], latch_enable_in};
    next_q.align_event = 1'b0;

    if (le_rise) begin
      next_q.le_level = 1'b1;
      // Readback does not block the write; the word is committed regardless.
      next_q.cfg[commit_addr] = commit_data;                           // [R2] [R4]
      next_q.last_addr = commit_addr;                                  // [R3]
      next_q.commit_count = q.commit_count + `COUNT_W'h1;
    end else if (le_fall) begin
      next_q.le_level = 1'b0;
      next_q.align_event = q.ctrl[`CTRL_ALIGN_BIT];                    // [R5]
    end

    // Write address and data are taken in either order
    if (aw_take) begin
      next_q.awaddr = s_axi_awaddr;
      next_q.aw_have = 1'b1;
      next_q.awready = 1'b0;
    end
    if (w_take) begin
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
      next_q.w_have = 1'b1;
      next_q.wready = 1'b0;
    end

    if (wr_go) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = wr_resp;
      if (wr_hit_ctrl) begin
        next_q.ctrl = ctrl_merged[1:0];
      end
    end

    if (b_take) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end

    if (ar_take) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_word;
      next_q.rresp = rd_resp;
    end

    if (r_take) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= `CTRL_RESET;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from state flops
  assign align_event   = q.align_event;
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

endmodule : three_wire_config_write_port

/* File: three_wire_config_write_port_properties.sv */
// Concurrent checks on the serial configuration port pins
`timescale 1ns/100ps
module three_wire_config_write_port_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched pins
  input wire logic latch_enable_in,
  input wire logic align_event,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_write_answered;
    s_axi_bvalid && s_axi_bready;
  endsequence
  property p_write_blocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_ready_after_b; s_write_answered |=> s_axi_awready && s_axi_wready; endproperty
  // Latch passes a synchroniser, so the pin was low two cycles before the pulse
  property p_align_after_fall; align_event |-> !$past(latch_enable_in, 2); endproperty
  property p_align_single; align_event |=> !align_event; endproperty
  property p_rvalid_after_ar; s_read_taken |=> s_axi_rvalid; endproperty
  property p_rvalid_holds; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  property p_bvalid_holds; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_align_after_fall: assert property (p_align_after_fall)
    else $error("align pulse without latch fall");
  a_align_single: assert property (p_align_single)
    else $error("align pulse longer than one cycle");
  a_rvalid_after_ar: assert property (p_rvalid_after_ar)
    else $error("read answer late");
  a_rvalid_holds: assert property (p_rvalid_holds)
    else $error("rvalid dropped early");
  a_bvalid_holds: assert property (p_bvalid_holds)
    else $error("bvalid dropped early");
  a_ar_blocked: assert property (p_ar_blocked)
    else $error("read taken while one outstanding");
  a_write_blocked: assert property (p_write_blocked)
    else $error("write taken while answer pending");
  a_ready_after_b: assert property (p_ready_after_b)
    else $error("write ready not back after answer");
endmodule : three_wire_config_write_port_properties

/* File: serial_host.sv */
// Host model driving the three serial configuration lines
`timescale 1ns/100ps
module serial_host (
  // Serial lines
  output logic sclk,
  output logic sdata,
  output logic latch
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch = 1'b0;
  end
  // MSB first; data moves 8 ns after each rise, keeping setup and hold
  task automatic send(input logic [31:0] w, input int extra);
    sdata = w[31];
    #25;
    for (int i = 0; i < 32; i++) begin
      #24 sclk = 1'b1;
      w = w << 1;
      #8 sdata = w[31];
      #16 sclk = 1'b0;
    end
    #25 latch = 1'b1;
    #30;
    repeat (extra) begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #25 latch = 1'b0;
  endtask : send
endmodule : serial_host

/* File: three_wire_config_write_port_tb.sv */
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
`include "cfg_port_map.svh"
module three_wire_config_write_port_tb;
  import cfg_port_pkg::*;
  typedef struct packed {logic [31:0] w; logic [7:0] a; logic [31:0] d;} row_t;
  row_t rows [3] = '{'{32'hffff_ffe0, 8'h00, 32'h07ff_ffff},
                     '{32'h0000_003f, 8'h7c, 32'h1},
                     '{32'ha5a5_a5a5, 8'h14, 32'h052d_2d2d}};
  logic clk = 1'b0, rst = 1'b0, sclk, sdata, latch, align_event;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  int err_count = 0, n_checks = 0, commits = 0, n_align = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (align_event === 1'b1) n_align <= n_align + 1;
  serial_host i_host (.sclk(sclk), .sdata(sdata), .latch(latch));
  three_wire_config_write_port i_dut (.clk(clk), .rst(rst), .serial_clock_in(sclk),
    .serial_data_in(sdata), .latch_enable_in(latch), .align_event(align_event),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Ready flags are registered, so the value seen at the falling edge holds at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, v;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awready; tw = wready; v = bvalid; r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!v);
    bready <= 1'b0;
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arready; v = rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd_chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    rd_chk(`STATUS_OFFSET, 32'h0, `RESP_OKAY);
    $display("reset test done");
    foreach (rows[i]) begin
      i_host.send(rows[i].w, 0);
      commits++;
      rd_chk(rows[i].a, rows[i].d, `RESP_OKAY);
      rd_chk(`STATUS_OFFSET, {commits[15:0], 11'h0, rows[i].w[4:0]}, `RESP_OKAY);
    end
    $display("table test done");
    wr(`CTRL_OFFSET, 32'h3, 4'hf);
    i_host.send(32'h0000_0c62, 3);
    repeat (8) @(posedge clk);
    chk("align", 32'h1, n_align);
    rd_chk(8'h08, 32'h63, `RESP_OKAY);
    wr(`CTRL_OFFSET, 32'h0, 4'hf);
    i_host.send(32'h0000_0c62, 0);
    repeat (8) @(posedge clk);
    chk("align", 32'h1, n_align);
    commits += 2;
    $display("alignment test done");
    i_host.send(32'hffff_fffa, 0);
    i_host.send(32'hffff_fffa, 0);
    commits += 2;
    rd_chk(`STATUS_OFFSET, {commits[15:0], 16'h001a}, `RESP_OKAY);
    wr(8'h68, 32'h0, 4'hf);
    rd_chk(8'h68, 32'h07ff_ffff, `RESP_OKAY);
    rd_chk(8'h88, 32'h0, `RESP_SLVERR);
    $display("double write test done");
    wr(`CTRL_OFFSET, 32'h3, 4'he);
    rd_chk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    wr(`CTRL_OFFSET, 32'h2, 4'h1);
    rd_chk(`CTRL_OFFSET, 32'h2, `RESP_OKAY);
    rd_chk(8'h02, 32'h0, `RESP_SLVERR);
    $display("strobe test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    rd_chk(`STATUS_OFFSET, 32'h0, `RESP_OKAY);
    rd_chk(8'h68, 32'h0, `RESP_OKAY);
    i_host.send(32'h0000_0c62, 0);
    rd_chk(`STATUS_OFFSET, 32'h0001_0002, `RESP_OKAY);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : three_wire_config_write_port_tb
bind three_wire_config_write_port three_wire_config_write_port_properties i_props (
  .clk(clk), .rst(rst), .latch_enable_in(latch_enable_in), .align_event(align_event),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
